// ===== rtl/isc_char_engine.sv
// ISO7816 character engine with AXI4-Lite registers
// Notes on behaviour
// [RULE1] Repeat count at maximum: flag, clear counter
// [RULE2] Acknowledged repeat stops and clears counter
// [RULE3] NACK limit enable caps successive receive NACKs
// [RULE4] At NACK cap: accept, ack, flag, clear
// [RULE5] T=1 runs asynchronous, one or two stops
// [RULE6] T=1 releases line after stop bits
// [RULE7] T=1 parity generated, checked, bad char stored
// [RULE8] T=1 never NACKs nor retransmits
// [RULE9] Collision check only with collision enable set
// [RULE10] Software enables both receiver and transmitter
// [RULE11] Each sent bit compared with line sample
// [RULE12] No collision flagged while transmitter idle
// [RULE13] Data read returns receive holding register
// [RULE14] Software reads data when receive complete
// [RULE15] Software reads status before data
// [RULE16] Data write loads transmit holding register
// [RULE17] Software writes data when holding empty
// [RULE18] Collision aborts character, releases line, flags
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none
module isc_char_engine (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [isc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [isc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe,
  output logic irq
);
  import isc_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [10:0] ctrl;
  logic [15:0] baud;
  logic [IF_W-1:0] intflag;
  logic [IF_W-1:0] intmask;
  logic [IF_W-1:0] ev;
  logic [IF_W-1:0] flag_clr;
  logic [8:0] tx_hold;
  logic [8:0] rx_data;
  logic [8:0] wr_char;
  logic hold_full;
  logic rx_full;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_en;
  logic rd_en;
  logic wr_data;
  logic [31:0] rd_val;
  logic [31:0] ctrl_m;
  logic [31:0] baud_m;
  logic [31:0] mask_m;
  logic [31:0] data_m;
  isc_tx_state_type tx_state;
  isc_rx_state_type rx_state;
  logic [3:0] tx_idx;
  logic [3:0] rx_idx;
  logic [3:0] stop_end;
  logic [7:0] tx_char;
  logic [9:0] tx_frame;
  logic [7:0] rx_shift;
  logic tx_par;
  logic tx_nack;
  logic tx_drive;
  logic tx_level;
  logic tx_load;
  logic tx_end;
  logic coll_hit;
  logic [2:0] tx_rep;
  logic [2:0] rx_cnt;
  logic [2:0] max_rep;
  logic rx_bad;
  logic rx_nack;
  logic rx_end_par;
  logic lim_hit;
  logic line_s;
  logic line_prev;
  logic t1;
  logic transmitter_enable;
  logic receiver_enable;
  logic collision_detect_enable;
  logic ev_rxc;
  logic ev_parity_error_flag;
  logic ev_iteration_limit_flag_tx;
  logic ev_iteration_limit_flag_rx;
  logic ev_coll;
  isc_bit_if tbt();
  isc_bit_if rbt();

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  assign t1 = ctrl[CB_T1];
  assign transmitter_enable = ctrl[CB_TRANSMITTER_ENABLE] && !ctrl[CB_SYNC]; // [RULE5]
  assign receiver_enable = ctrl[CB_RECEIVER_ENABLE] && !ctrl[CB_SYNC]; // [RULE5]
  assign collision_detect_enable = ctrl[CB_COLLISION_DETECT_ENABLE] && ctrl[CB_TRANSMITTER_ENABLE] && ctrl[CB_RECEIVER_ENABLE]; // [RULE9] [RULE10]
  assign max_rep = ctrl[CB_MAX +: MAX_W];
  assign lim_hit = ctrl[CB_NACKLIM] && rx_cnt == max_rep; // [RULE3]
  // Last stop or guard position of a frame
  assign stop_end = (t1 && !ctrl[CB_STOP2]) ? IDX_STOP : IDX_GUARD; // [RULE5]

  // ----------------------------------------
  // Line pins and timers
  // ----------------------------------------
  isc_sync2 u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(line_i),
    .q(line_s)
  );

  isc_bit_timer u_tx_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .bt(tbt)
  );

  isc_bit_timer u_rx_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .bt(rbt)
  );

  // Timers run only while a frame is active
  assign tbt.restart = tx_state == TX_IDLE;
  assign tbt.period = baud;
  assign rbt.restart = rx_state == RX_IDLE;
  assign rbt.period = baud;

  // Line drive, NACK pulls low
  assign line_oe = tx_drive || rx_nack;
  assign line_o = tx_drive && tx_level;

  // Previous line sample for start edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_prev <= 1'b1;
    end else begin
      line_prev <= line_s;
    end
  end

  // ----------------------------------------
  // Bus write channels
  // ----------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_en = aw_held && w_held && !s_axi_bvalid;
  assign wr_data = wr_en && aw_addr == ADDR_DATA;

  // Address and data capture in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_en) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_en) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isc_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Bus read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_en = s_axi_arvalid && s_axi_arready;

  // Read mux; status = rep count, rx busy, tx busy, hold full, rx full
  always_comb begin
    case (s_axi_araddr)
      ADDR_CTRL: rd_val = {21'h000000, ctrl};
      ADDR_BAUD: rd_val = {16'h0000, baud};
      ADDR_STATUS: rd_val = {25'h0000000, tx_rep, rx_state != RX_IDLE, tx_state != TX_IDLE, hold_full, rx_full};
      ADDR_INTFLAG: rd_val = {27'h0000000, intflag};
      ADDR_INTMASK: rd_val = {27'h0000000, intmask};
      ADDR_DATA: rd_val = {23'h000000, rx_data}; // [RULE13]
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= isc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  assign ctrl_m = isc_merge({21'h000000, ctrl}, w_data, w_strb);
  assign baud_m = isc_merge({16'h0000, baud}, w_data, w_strb);
  assign mask_m = isc_merge({27'h0000000, intmask}, w_data, w_strb);
  assign data_m = isc_merge({23'h000000, tx_hold}, w_data, w_strb);
  assign wr_char = data_m[8:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_en && aw_addr == ADDR_CTRL) begin
      ctrl <= ctrl_m[10:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud <= BAUD_RESET;
    end else if (wr_en && aw_addr == ADDR_BAUD) begin
      baud <= baud_m[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intmask <= IF_RESET;
    end else if (wr_en && aw_addr == ADDR_INTMASK) begin
      intmask <= mask_m[IF_W-1:0];
    end
  end

  // Sticky flags, write one to clear, set wins
  assign ev[IF_RXC] = ev_rxc;
  assign ev[IF_DRE] = tx_load;
  assign ev[IF_PARITY_ERROR_FLAG] = ev_parity_error_flag;
  assign ev[IF_ITERATION_LIMIT_FLAG] = ev_iteration_limit_flag_tx || ev_iteration_limit_flag_rx;
  assign ev[IF_COLL] = ev_coll;
  assign flag_clr = (wr_en && aw_addr == ADDR_INTFLAG && w_strb[0]) ? w_data[IF_W-1:0] : IF_RESET;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intflag <= IF_RESET;
    end else begin
      intflag <= (intflag & ~flag_clr) | ev;
    end
  end

  assign irq = |(intflag & intmask);

  // Transmit holding register, separate from receive side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold <= DATA_RESET;
      hold_full <= 1'b0;
    end else if (wr_data) begin
      tx_hold <= wr_char; // [RULE16]
      hold_full <= 1'b1;
    end else if (tx_load) begin
      hold_full <= 1'b0;
    end
  end

  // Receive holding full, emptied by data read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full <= 1'b0;
    end else if (ev_rxc) begin
      rx_full <= 1'b1;
    end else if (rd_en && s_axi_araddr == ADDR_DATA) begin
      rx_full <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign tx_load = tx_state == TX_IDLE && transmitter_enable && hold_full && rx_state == RX_IDLE;
  assign tx_frame = {tx_par, tx_char, 1'b0};
  assign coll_hit = collision_detect_enable && tx_drive && tbt.mid && (line_s != tx_level); // [RULE11] [RULE12]
  assign tx_end = tx_state == TX_STOP && tbt.done && tx_idx == stop_end && !coll_hit;

  // Frame sequencer, guard sampling and repetition
  always_ff @(posedge aclk) begin
    ev_coll <= 1'b0;
    ev_iteration_limit_flag_tx <= 1'b0;
    if (!aresetn) begin
      tx_state <= TX_IDLE;
      tx_idx <= IDX_START;
      tx_char <= 8'h00;
      tx_par <= 1'b0;
      tx_rep <= 3'h0;
      tx_nack <= 1'b0;
      tx_drive <= 1'b0;
      tx_level <= 1'b1;
    end else if (tx_state != TX_IDLE && coll_hit) begin
      tx_state <= TX_IDLE; // [RULE18]
      tx_drive <= 1'b0;
      tx_level <= 1'b1;
      tx_rep <= 3'h0;
      ev_coll <= 1'b1;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_load) begin
            tx_char <= tx_hold[7:0];
            tx_par <= ^tx_hold[7:0]; // [RULE7]
            tx_state <= TX_BITS;
            tx_idx <= IDX_START;
            tx_drive <= 1'b1;
            tx_level <= 1'b0;
            tx_nack <= 1'b0;
          end
        end
        TX_BITS: begin
          if (tbt.done) begin
            tx_idx <= tx_idx + 4'h1;
            if (tx_idx == IDX_PARITY) begin
              tx_state <= TX_STOP;
              tx_drive <= t1; // [RULE6]
              tx_level <= 1'b1;
            end else begin
              tx_level <= tx_frame[tx_idx + 4'h1];
            end
          end
        end
        TX_STOP: begin
          if (tbt.mid && tx_idx == IDX_STOP && !t1) begin
            tx_nack <= !line_s;
          end
          if (tbt.done) begin
            if (tx_idx != stop_end) begin
              tx_idx <= tx_idx + 4'h1;
            end else if (tx_nack && !t1 && tx_rep != max_rep) begin
              tx_rep <= tx_rep + 3'h1; // [RULE8]
              tx_state <= TX_BITS;
              tx_idx <= IDX_START;
              tx_drive <= 1'b1;
              tx_level <= 1'b0;
              tx_nack <= 1'b0;
            end else begin
              tx_state <= TX_IDLE; // [RULE6]
              tx_drive <= 1'b0;
              tx_rep <= 3'h0; // [RULE1] [RULE2]
              tx_nack <= 1'b0;
              ev_iteration_limit_flag_tx <= tx_nack && !t1; // [RULE1]
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
          tx_drive <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign rx_end_par = rx_state == RX_BITS && rbt.done && rx_idx == IDX_PARITY;

  // Sampling, parity check and NACK decision
  always_ff @(posedge aclk) begin
    ev_rxc <= 1'b0;
    ev_parity_error_flag <= 1'b0;
    ev_iteration_limit_flag_rx <= 1'b0;
    if (!aresetn) begin
      rx_state <= RX_IDLE;
      rx_idx <= IDX_START;
      rx_shift <= 8'h00;
      rx_bad <= 1'b0;
      rx_cnt <= 3'h0;
      rx_nack <= 1'b0;
      rx_data <= DATA_RESET;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (receiver_enable && tx_state == TX_IDLE && line_prev && !line_s) begin
            rx_state <= RX_BITS; // [RULE12]
            rx_idx <= IDX_START;
          end
        end
        RX_BITS: begin
          if (rbt.mid) begin
            if (rx_idx == IDX_START && line_s) begin
              rx_state <= RX_IDLE;
            end else if (rx_idx == IDX_PARITY) begin
              rx_bad <= (^rx_shift) != line_s; // [RULE7]
            end else if (rx_idx != IDX_START) begin
              rx_shift <= {line_s, rx_shift[7:1]};
            end
          end
          if (rbt.done) begin
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == IDX_PARITY) begin
              rx_state <= RX_STOP;
              if (rx_bad && !t1 && !lim_hit) begin
                rx_nack <= 1'b1; // [RULE3]
                rx_cnt <= rx_cnt + 3'h1;
                ev_parity_error_flag <= 1'b1;
              end else begin
                rx_data <= {1'b0, rx_shift}; // [RULE4] [RULE7] [RULE8]
                ev_rxc <= 1'b1;
                rx_cnt <= 3'h0;
                ev_parity_error_flag <= rx_bad && t1;
                ev_iteration_limit_flag_rx <= rx_bad && !t1; // [RULE4]
              end
            end
          end
        end
        RX_STOP: begin
          if (rbt.done) begin
            rx_state <= RX_IDLE;
            rx_nack <= 1'b0;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
          rx_nack <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_iteration_limit_flag_tx;
    tx_end && tx_nack && !t1 && tx_rep == max_rep |=> tx_rep == 3'h0 && tx_state == TX_IDLE ##1 intflag[IF_ITERATION_LIMIT_FLAG];
  endproperty
  a_iteration_limit_flag_tx: assert property (p_iteration_limit_flag_tx) else $error("iteration limit not flagged"); // [RULE1]

  property p_ack_tx;
    tx_end && !tx_nack |=> tx_rep == 3'h0 && !tx_drive;
  endproperty
  a_ack_tx: assert property (p_ack_tx) else $error("acknowledged char not ended"); // [RULE2]

  property p_nack_lim;
    rx_end_par && rx_bad && !t1 && lim_hit |=> !rx_nack && rx_cnt == 3'h0 ##1 intflag[IF_ITERATION_LIMIT_FLAG] && rx_full;
  endproperty
  a_nack_lim: assert property (p_nack_lim) else $error("NACK limit not applied"); // [RULE3] [RULE4]

  property p_sync_off;
    ctrl[CB_SYNC] && tx_state == TX_IDLE |=> tx_state == TX_IDLE;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("frame sent in sync mode"); // [RULE5]

  property p_t1_release;
    tx_end && t1 |=> tx_state == TX_IDLE && !line_oe;
  endproperty
  a_t1_release: assert property (p_t1_release) else $error("line held after stop"); // [RULE6] [RULE8]

  property p_t1_parity_error_flag;
    rx_end_par && rx_bad && t1 |=> !rx_nack && rx_data == {1'b0, $past(rx_shift)} ##1 intflag[IF_PARITY_ERROR_FLAG] && rx_full;
  endproperty
  a_t1_parity_error_flag: assert property (p_t1_parity_error_flag) else $error("bad parity char lost"); // [RULE7] [RULE8]

  property p_coll;
    coll_hit |=> tx_state == TX_IDLE && !line_oe ##1 intflag[IF_COLL];
  endproperty
  a_coll: assert property (p_coll) else $error("collision not handled"); // [RULE11] [RULE18]

  property p_coll_cause;
    ev_coll |-> $past(collision_detect_enable) && $past(tx_drive);
  endproperty
  a_coll_cause: assert property (p_coll_cause) else $error("collision without cause"); // [RULE9] [RULE12]

  property p_rd_data;
    rd_en && s_axi_araddr == ADDR_DATA |=> s_axi_rvalid && s_axi_rdata[8:0] == $past(rx_data);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("data read mismatch"); // [RULE13]

  property p_wr_data;
    wr_data |=> hold_full && tx_hold == $past(wr_char);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("holding register not loaded"); // [RULE16]
endmodule : isc_char_engine
`default_nettype wire

// ===== rtl/isc_pkg.sv
// Constants, types and helpers of the ISO7816 character engine
`default_nettype none
package isc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INTFLAG = 8'h0C;
  localparam logic [7:0] ADDR_INTMASK = 8'h10;
  localparam logic [7:0] ADDR_DATA = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CB_TRANSMITTER_ENABLE = 0;
  localparam int CB_RECEIVER_ENABLE = 1;
  localparam int CB_COLLISION_DETECT_ENABLE = 2;
  localparam int CB_NACKLIM = 3;
  localparam int CB_T1 = 4;
  localparam int CB_STOP2 = 5;
  localparam int CB_SYNC = 6;
  localparam int CB_MAX = 8;
  localparam int MAX_W = 3;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [15:0] BAUD_RESET = 16'h0173;
  localparam logic [8:0] DATA_RESET = 9'h000;
  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  localparam int IF_RXC = 0;
  localparam int IF_DRE = 1;
  localparam int IF_PARITY_ERROR_FLAG = 2;
  localparam int IF_ITERATION_LIMIT_FLAG = 3;
  localparam int IF_COLL = 4;
  localparam int IF_W = 5;
  localparam logic [4:0] IF_RESET = 5'h00;
  // ----------------------------------------
  // Frame positions and states
  // ----------------------------------------
  localparam logic [3:0] IDX_START = 4'h0;
  localparam logic [3:0] IDX_PARITY = 4'h9;
  localparam logic [3:0] IDX_STOP = 4'hA;
  localparam logic [3:0] IDX_GUARD = 4'hB;
  typedef enum logic [2:0] {TX_IDLE = 3'h1, TX_BITS = 3'h2, TX_STOP = 3'h4} isc_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE = 3'h1, RX_BITS = 3'h2, RX_STOP = 3'h4} isc_rx_state_type;

  // Byte-lane merge of a bus write
  function automatic logic [31:0] isc_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      isc_merge[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : isc_merge

  // Address decode of the register map
  function automatic logic isc_mapped(input logic [7:0] addr);
    return addr inside {ADDR_CTRL, ADDR_BAUD, ADDR_STATUS, ADDR_INTFLAG, ADDR_INTMASK, ADDR_DATA};
  endfunction : isc_mapped
endpackage : isc_pkg
`default_nettype wire

// ===== rtl/isc_bit_if.sv
// Interface between the character engine and a bit timer
`default_nettype none
interface isc_bit_if;
  logic restart;
  logic [15:0] period;
  logic mid;
  logic done;
  modport timer(input restart, input period, output mid, output done);
  modport user(output restart, output period, input mid, input done);
endinterface : isc_bit_if
`default_nettype wire

// ===== rtl/isc_bit_timer.sv
// Bit period timer with mid-bit and end-of-bit strobes
`default_nettype none
module isc_bit_timer (
  input wire logic aclk,
  input wire logic aresetn,
  isc_bit_if.timer bt
);
  import isc_pkg::*;
  logic [15:0] count;

  // Counts period+1 cycles, held at zero by restart
  always_ff @(posedge aclk) begin
    if (!aresetn || bt.restart || count == bt.period) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

  // Strobes
  assign bt.mid = !bt.restart && (count == (bt.period >> 1));
  assign bt.done = !bt.restart && (count == bt.period);
endmodule : isc_bit_timer
`default_nettype wire

// ===== rtl/isc_sync2.sv
// Two-flop synchroniser for the serial line
`default_nettype none
module isc_sync2 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic d,
  output logic q
);
  import isc_pkg::*;
  logic meta;

  // Idle line level is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : isc_sync2
`default_nettype wire

// ===== verification/isc_card.sv
// Smart card model on the open-drain serial line
`default_nettype none
module isc_card #(parameter int BIT = 8) (
  input wire logic aclk,
  input wire logic line,
  output logic card_low
);
  timeunit 1ns;
  timeprecision 1ps;
  int nack_left = 0;
  int jam_idx = -1;
  int bad_par = 0;
  logic sending = 1'b0;
  logic [7:0] rx_q[$];
  logic [9:0] bits;
  initial card_low = 1'b0;
  // Take device frames, jam a bit or refuse on command
  always begin
    @(negedge line);
    if (!sending) begin
      repeat (BIT / 2) @(posedge aclk);
      for (int i = 1; i < 10; i++) begin
        card_low <= (i == jam_idx);
        repeat (BIT) @(posedge aclk);
        bits[i] = line;
      end
      card_low <= 1'b0;
      rx_q.push_back(bits[8:1]);
      if (^bits[9:1])
        bad_par++;
      repeat (BIT / 2) @(posedge aclk);
      card_low <= (nack_left > 0);
      if (nack_left > 0)
        nack_left--;
      repeat (BIT + 4) @(posedge aclk);
      card_low <= 1'b0;
    end
  end
  // Send one frame with even parity, spoilt on request
  task automatic send(input logic [7:0] d, input logic bad, output logic nacked);
    logic [9:0] f;
    f = {(^d) ^ bad, d, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 10; i++) begin
      card_low <= !f[i];
      repeat (BIT) @(posedge aclk);
    end
    card_low <= 1'b0;
    repeat (BIT / 2 + 2) @(posedge aclk);
    nacked = !line;
    repeat (BIT + 2) @(posedge aclk);
    sending = 1'b0;
  endtask : send
endmodule : isc_card
`default_nettype wire

// ===== verification/tb.sv
// Self-checking testbench of the ISO7816 character engine
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import isc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp_seen;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, line_o, line_oe, irq, card_low;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int oe_n = 0;
  wire logic line_w = !((line_oe && !line_o) || card_low);
  isc_char_engine i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .line_i(line_w), .line_o, .line_oe, .irq);
  isc_card #(.BIT(8)) i_card (.aclk, .line(line_w), .card_low);
  // Clock and hang guard
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (line_oe === 1'b1)
      oe_n++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Bus write, channels released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask : wr
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rresp_seen = s_axi_rresp;
    chk(what, s_axi_rdata & m, e);
    @(posedge aclk);
  endtask : rdchk
  // Frames seen by the card against the expected byte and count
  task automatic card_chk(input logic [7:0] b, input int n);
    chk("frames", 32'(i_card.rx_q.size()), 32'(n));
    chk("card parity", 32'(i_card.bad_par), 32'h0);
    while (i_card.rx_q.size() > 0)
      chk("card byte", 32'(i_card.rx_q.pop_front()), 32'(b));
  endtask : card_chk
  // Main sequence
  initial begin
    logic [7:0] b;
    logic nk;
    void'($urandom(57));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk("data reset", ADDR_DATA, 32'hFFFF, 32'h0);
    rdchk("unmapped", 8'h3C, 32'hFFFFFFFF, 32'h0);
    chk("rresp", 32'(rresp_seen), 32'(RESP_SLVERR));
    wr(8'h3C, 32'hFFFFFFFF, RESP_SLVERR);
    wr(ADDR_BAUD, 32'h7);
    b = 8'($urandom);
    // Sync select holds the frame back, then one and two stop bits
    for (int k = 0; k < 3; k++) begin
      oe_n = 0;
      wr(ADDR_CTRL, k == 0 ? 32'h53 : (k == 1 ? 32'h13 : 32'h33));
      if (k != 1)
        wr(ADDR_DATA, {23'h0, 1'b1, b});
      repeat (150) @(posedge aclk);
      card_chk(b, k != 0);
      chk("t1 drive", 32'(oe_n), 32'(k == 0 ? 0 : (k + 10) * 8));
      chk("t1 release", 32'(line_oe), 32'h0);
    end
    rdchk("rx apart", ADDR_DATA, 32'h1FF, 32'h0);
    rdchk("dre", ADDR_INTFLAG, 32'h2, 32'h2);
    chk("irq masked", 32'(irq), 32'h0);
    wr(ADDR_INTMASK, 32'h1);
    wr(ADDR_INTFLAG, 32'h1F);
    b = 8'($urandom);
    i_card.send(b, 1'b1, nk);
    chk("t1 nack", 32'(nk), 32'h0);
    chk("irq set", 32'(irq), 32'h1);
    rdchk("t1 parity_error_flag", ADDR_INTFLAG, 32'h5, 32'h5);
    rdchk("t1 char", ADDR_DATA, 32'h1FF, 32'(b));
    wr(ADDR_INTFLAG, 32'h1F);
    chk("irq clear", 32'(irq), 32'h0);
    wr(ADDR_CTRL, 32'h203);
    for (int k = 3; k > 0; k -= 2) begin
      i_card.nack_left = k;
      wr(ADDR_INTFLAG, 32'h1F);
      wr(ADDR_DATA, 32'(b));
      repeat (500) @(posedge aclk);
      card_chk(b, (k > 2 ? 2 : k) + 1);
      rdchk("iteration_limit_flag", ADDR_INTFLAG, 32'h8, k > 2 ? 32'h8 : 32'h0);
      rdchk("repeats", ADDR_STATUS, 32'h70, 32'h0);
    end
    wr(ADDR_CTRL, 32'h10B);
    wr(ADDR_INTFLAG, 32'h1F);
    b = 8'($urandom);
    for (int k = 0; k < 3; k++) begin
      i_card.send(b, 1'b1, nk);
      chk("nack", 32'(nk), 32'(k != 1));
    end
    rdchk("nack cap", ADDR_INTFLAG, 32'h9, 32'h9);
    rdchk("cap char", ADDR_DATA, 32'h1FF, 32'(b));
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, k ? 32'h3 : 32'h7);
      wr(ADDR_INTFLAG, 32'h1F);
      i_card.jam_idx = 3;
      wr(ADDR_DATA, 32'hFF);
      while (!line_oe) @(posedge aclk);
      repeat (40) @(posedge aclk);
      chk("jam drive", 32'(line_oe), 32'(k));
      repeat (200) @(posedge aclk);
      rdchk("coll", ADDR_INTFLAG, 32'h10, k ? 32'h0 : 32'h10);
      i_card.jam_idx = -1;
      i_card.rx_q.delete();
    end
    wr(ADDR_CTRL, 32'h7);
    wr(ADDR_INTFLAG, 32'h1F);
    b = 8'($urandom);
    i_card.send(b, 1'b0, nk);
    rdchk("rx no coll", ADDR_INTFLAG, 32'h11, 32'h1);
    rdchk("rx char", ADDR_DATA, 32'h1FF, 32'(b));
    give_verdict();
  end
endmodule : tb
`default_nettype wire
